// ---- hdl/dma_crc_defs.svh ----
// Summary of operation
// - Status direction bit reads 1 after a DMA read, 0 after a write.
// - Status channel field holds the most recently active DMA channel.
// - Address register captures the bus address of the latest DMA access.
// - Byte order: 00 keep, 01 reverse word, 10 swap halves, 11 swap bytes.
// - Write-reorder set writes reordered data for the routed channel only; clear writes data unchanged.
// - CRC type 1 selects IP header checksum, 0 selects LFSR CRC.
// - Checksum mode: bit-order set computes LSb first, clear MSb first.
// - LFSR mode: bit-order set computes LSb first, clear MSb first.
// - Polynomial length field holds length minus one; ignored in checksum mode.
// - Engine enabled routes selected channel through CRC; disabled leaves it alone.
// - Append mode feeds source data to the CRC only, no destination write.
// - Append mode writes the result to destination start at block end.
// - Append clear passes data through CRC and writes it, honouring reorder.
// - Append bit cannot be set while write-reorder is set.
// - Unimplemented bits read zero; implemented bits reset to zero.
`ifndef DMA_CRC_DEFS_SVH
`define DMA_CRC_DEFS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define OFS_STATUS     8'h00
`define OFS_LAST_ADDR  8'h04
`define OFS_CONTROL    8'h08
`define OFS_POLY       8'h0c
`define OFS_CRC_DATA   8'h10

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define STAT_DIR_BIT   3
`define STAT_CH_LSB    0
`define CTL_BYTE_ORDER_SEL_LSB   28
`define CTL_WBO_BIT    27
`define CTL_BIT_REFLECT_SEL_BIT   24
`define CTL_POLY_LENGTH_M1_LSB   8
`define CTL_EN_BIT     7
`define CTL_APP_BIT    6
`define CTL_TYP_BIT    5
`define CTL_CH_LSB     0
`define CTL_IMPL_MASK  32'h39001fe7
`define STAT_IMPL_MASK 32'h0000000f

// ----------------------------------------------------------------------
// Reset values and bus answers
// ----------------------------------------------------------------------
`define RST_WORD       32'h00000000
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`endif

// ---- hdl/dma_crc_pkg.sv ----
package dma_crc_pkg;

    // Byte order selections applied ahead of the engine.
    typedef enum logic [1:0] {
        BO_KEEP      = 2'h0,
        BO_REV_WORD  = 2'h1,
        BO_SWAP_HALF = 2'h2,
        BO_SWAP_BYTE = 2'h3
    } byte_order_e;

    // Write channel progress, Gray coded along idle, wait, respond.
    typedef enum logic [1:0] {
        WR_IDLE = 2'h0,
        WR_WAIT = 2'h1,
        WR_RESP = 2'h3
    } wr_state_e;

    typedef logic [31:0] word_t;

endpackage : dma_crc_pkg

// ---- hdl/crc_engine.sv ----
`timescale 1ns/1ns
module crc_engine (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // Control
    input  wire logic        seedLoad,
    input  wire logic [31:0] seedValue,
    input  wire logic        wordValid,
    input  wire logic [31:0] wordData,
    input  wire logic        checksumMode,
    input  wire logic        reflect,
    input  wire logic [4:0]  polyLenM1,
    input  wire logic [31:0] poly,
    // Result
    output logic      [31:0] crc_q
);

    // ------------------------------------------------------------------
    // Arithmetic helpers
    // ------------------------------------------------------------------
    function automatic logic [15:0] rev16(input logic [15:0] v);
        logic [15:0] r;
        r = '0;
        for (int i = 0; i < 16; i++)
        begin
            r[i] = v[15-i];
        end
        return r;
    endfunction : rev16

    // Ones-complement addition with the end-around carry folded back in.
    function automatic logic [15:0] onesAdd(input logic [15:0] a,
                                            input logic [15:0] b);
        logic [16:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[15:0] + {15'h0000, s[16]};
    endfunction : onesAdd

    // One whole word shifted through a Galois register of chosen length.
    function automatic logic [31:0] lfsrWord(input logic [31:0] c,
                                             input logic [31:0] d,
                                             input logic [31:0] p,
                                             input logic [4:0]  len,
                                             input logic        refl);
        logic [31:0] r;
        logic [31:0] m;
        logic        fb;
        logic        din;
        r  = c;
        m  = 32'hffffffff >> (5'd31 - len);
        fb = 1'b0;
        for (int i = 0; i < 32; i++)
        begin
            din = refl ? d[i] : d[31-i];
            if (refl)
            begin
                fb = r[0] ^ din;
                r  = r >> 1;
            end
            else
            begin
                fb = r[len] ^ din;
                r  = (r << 1) & m;
            end
            if (fb)
            begin
                r = r ^ (p & m);
            end
        end
        return r & m;
    endfunction : lfsrWord

    // ------------------------------------------------------------------
    // Accumulator
    // ------------------------------------------------------------------
    logic [15:0] hiHalf;
    logic [15:0] loHalf;
    logic [15:0] sumNext;

    // Reflection reverses each half before it joins the sum.
    always_comb
    begin
        hiHalf  = reflect ? rev16(wordData[31:16]) : wordData[31:16];
        loHalf  = reflect ? rev16(wordData[15:0]) : wordData[15:0];
        sumNext = onesAdd(onesAdd(crc_q[15:0], hiHalf), loHalf);
    end

    // The seed write wins over a word arriving the same cycle.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            crc_q <= 32'h00000000;
        end
        else if (seedLoad)
        begin
            crc_q <= seedValue;
        end
        else if (wordValid)
        begin
            if (checksumMode)
            begin
                crc_q <= {16'h0000, sumNext};
            end
            else
            begin
                crc_q <= lfsrWord(crc_q, wordData, poly, polyLenM1,
                                  reflect);
            end
        end
    end

endmodule : crc_engine

// ---- hdl/dma_crc_unit.sv ----
`timescale 1ns/1ns
`include "dma_crc_defs.svh"
module dma_crc_unit (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // AXI4-Lite write address and data
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    // AXI4-Lite write response
    output logic      [1:0]  bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // AXI4-Lite read
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic      [31:0] rdata,
    output logic      [1:0]  rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // DMA bus access monitor
    input  wire logic        busAccValid,
    input  wire logic        busAccRead,
    input  wire logic [2:0]  busAccChannel,
    input  wire logic [31:0] busAccAddr,
    // Source beats from the channel datapath
    input  wire logic        srcValid,
    input  wire logic [2:0]  srcChannel,
    input  wire logic [31:0] srcData,
    input  wire logic [31:0] srcDestAddr,
    // Block completion
    input  wire logic        blockDone,
    input  wire logic [2:0]  blockChannel,
    input  wire logic [31:0] chanDestStartAddr,
    // Destination writes
    output logic             dstValid,
    output logic      [31:0] dstAddr,
    output logic      [31:0] dstData,
    output logic             dstIsResult
);

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic                      lastAccessDir_q;
    logic [2:0]                lastActiveChannel_q;
    dma_crc_pkg::word_t        dmaLastAddress_q;
    dma_crc_pkg::word_t        control_q;
    dma_crc_pkg::word_t        poly_q;
    dma_crc_pkg::word_t        crcValue;
    dma_crc_pkg::wr_state_e    wrState_q;
    logic [7:0]                wrAddr_q;
    dma_crc_pkg::word_t        wrData_q;
    logic [3:0]                wrStrb_q;
    logic                      awHeld_q;
    logic                      wHeld_q;
    logic                      awready_q;
    logic                      wready_q;
    logic                      bvalid_q;
    logic [1:0]                bresp_q;
    logic                      arready_q;
    logic                      rvalid_q;
    logic [1:0]                rresp_q;
    dma_crc_pkg::word_t        rdata_q;
    logic                      dstValid_q;
    dma_crc_pkg::word_t        dstAddr_q;
    dma_crc_pkg::word_t        dstData_q;
    logic                      dstIsResult_q;

    // ------------------------------------------------------------------
    // Control field decode
    // ------------------------------------------------------------------
    dma_crc_pkg::byte_order_e  byteOrderSel;
    logic                      writeReorderEn;
    logic                      bitReflectSel;
    logic [4:0]                polyLengthM1;
    logic                      crcEngineEn;
    logic                      appendResultMode;
    logic                      crcTypeSel;
    logic [2:0]                crcChannelSel;

    assign byteOrderSel     = dma_crc_pkg::byte_order_e'(
                                  control_q[`CTL_BYTE_ORDER_SEL_LSB +: 2]);
    assign writeReorderEn   = control_q[`CTL_WBO_BIT];
    assign bitReflectSel    = control_q[`CTL_BIT_REFLECT_SEL_BIT];
    assign polyLengthM1     = control_q[`CTL_POLY_LENGTH_M1_LSB +: 5];
    assign crcEngineEn      = control_q[`CTL_EN_BIT];
    assign appendResultMode = control_q[`CTL_APP_BIT];
    assign crcTypeSel       = control_q[`CTL_TYP_BIT];
    assign crcChannelSel    = control_q[`CTL_CH_LSB +: 3];

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Byte reordering shared by the engine feed and the destination path.
    function automatic logic [31:0] reorder(input logic [31:0] d,
                                            input dma_crc_pkg::byte_order_e s);
        logic [31:0] r;
        r = d;
        unique case (s)
            dma_crc_pkg::BO_KEEP:      r = d;
            dma_crc_pkg::BO_REV_WORD:  r = {d[7:0], d[15:8], d[23:16],
                                            d[31:24]};
            dma_crc_pkg::BO_SWAP_HALF: r = {d[15:0], d[31:16]};
            dma_crc_pkg::BO_SWAP_BYTE: r = {d[23:16], d[31:24], d[7:0],
                                            d[15:8]};
        endcase
        return r;
    endfunction : reorder

    // Byte-lane merge of a write into an existing word.
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction : merge

    // ------------------------------------------------------------------
    // Datapath steering
    // ------------------------------------------------------------------
    logic               routed;
    logic               appendDone;
    dma_crc_pkg::word_t orderedData;

    // Only the selected channel sees the engine, and only while enabled.
    always_comb
    begin
        routed      = crcEngineEn && srcValid
                      && (srcChannel == crcChannelSel);
        orderedData = reorder(srcData, byteOrderSel);
        appendDone  = crcEngineEn && appendResultMode && blockDone
                      && (blockChannel == crcChannelSel);
    end

    // ------------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------------
    logic wrFire;
    logic wrHit;
    logic seedLoad;

    assign wrFire   = (wrState_q == dma_crc_pkg::WR_WAIT)
                      && awHeld_q && wHeld_q;
    assign wrHit    = (wrAddr_q <= `OFS_CRC_DATA); // Offsets are contiguous.
    assign seedLoad = wrFire && (wrAddr_q == `OFS_CRC_DATA);

    // Address and data are taken in either order; the answer follows both.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wrState_q <= dma_crc_pkg::WR_IDLE;
            awHeld_q  <= 1'b0;
            wHeld_q   <= 1'b0;
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= `RESP_OKAY;
            wrAddr_q  <= 8'h00;
            wrData_q  <= `RST_WORD;
            wrStrb_q  <= 4'h0;
        end
        else
        begin
            unique case (wrState_q)
                dma_crc_pkg::WR_IDLE:
                begin
                    awready_q <= 1'b1;
                    wready_q  <= 1'b1;
                    wrState_q <= dma_crc_pkg::WR_WAIT;
                end
                dma_crc_pkg::WR_WAIT:
                begin
                    if (awvalid && awready_q)
                    begin
                        wrAddr_q  <= {awaddr[7:2], 2'b00};
                        awHeld_q  <= 1'b1;
                        awready_q <= 1'b0;
                    end
                    if (wvalid && wready_q)
                    begin
                        wrData_q <= wdata;
                        wrStrb_q <= wstrb;
                        wHeld_q  <= 1'b1;
                        wready_q <= 1'b0;
                    end
                    if (wrFire)
                    begin
                        awHeld_q  <= 1'b0;
                        wHeld_q   <= 1'b0;
                        bvalid_q  <= 1'b1;
                        bresp_q   <= wrHit ? `RESP_OKAY : `RESP_SLVERR;
                        wrState_q <= dma_crc_pkg::WR_RESP;
                    end
                end
                dma_crc_pkg::WR_RESP:
                begin
                    if (bready)
                    begin
                        bvalid_q  <= 1'b0;
                        wrState_q <= dma_crc_pkg::WR_IDLE;
                    end
                end
                default:
                begin
                    wrState_q <= dma_crc_pkg::WR_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------------
    dma_crc_pkg::word_t ctlWrite;

    // Append is forced clear when the written word also asks for reorder.
    always_comb
    begin
        ctlWrite = merge(control_q, wrData_q, wrStrb_q)
                   & `CTL_IMPL_MASK;
        if (ctlWrite[`CTL_WBO_BIT])
        begin
            ctlWrite[`CTL_APP_BIT] = 1'b0;
        end
    end

    // Control and polynomial words; reset to zero.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            control_q <= `RST_WORD;
            poly_q    <= `RST_WORD;
        end
        else if (wrFire && (wrAddr_q == `OFS_CONTROL))
        begin
            control_q <= ctlWrite;
        end
        else if (wrFire && (wrAddr_q == `OFS_POLY))
        begin
            poly_q <= merge(poly_q, wrData_q, wrStrb_q);
        end
    end

    // ------------------------------------------------------------------
    // DMA access monitor
    // ------------------------------------------------------------------
    // Direction, channel and address of the latest bus access.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            lastAccessDir_q     <= 1'b0;
            lastActiveChannel_q <= 3'h0;
            dmaLastAddress_q    <= `RST_WORD;
        end
        else if (busAccValid)
        begin
            lastAccessDir_q     <= busAccRead;
            lastActiveChannel_q <= busAccChannel;
            dmaLastAddress_q    <= busAccAddr;
        end
    end

    // ------------------------------------------------------------------
    // Engine
    // ------------------------------------------------------------------
    crc_engine engine (
        .clk          (clk),
        .rst_b        (rst_b),
        .seedLoad     (seedLoad),
        .seedValue    (merge(crcValue, wrData_q, wrStrb_q)),
        .wordValid    (routed),
        .wordData     (orderedData),
        .checksumMode (crcTypeSel),
        .reflect      (bitReflectSel),
        .polyLenM1    (polyLengthM1),
        .poly         (poly_q),
        .crc_q        (crcValue)
    );

    // ------------------------------------------------------------------
    // Destination writes
    // ------------------------------------------------------------------
    // Result write at block end takes precedence; the source side does
    // not send a data beat in the same cycle as the completion.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            dstValid_q    <= 1'b0;
            dstAddr_q     <= `RST_WORD;
            dstData_q     <= `RST_WORD;
            dstIsResult_q <= 1'b0;
        end
        else if (appendDone)
        begin
            dstValid_q    <= 1'b1;
            dstAddr_q     <= chanDestStartAddr;
            dstData_q     <= crcValue;
            dstIsResult_q <= 1'b1;
        end
        else
        begin
            dstValid_q    <= srcValid
                             && !(routed && appendResultMode);
            dstAddr_q     <= srcDestAddr;
            dstData_q     <= (routed && writeReorderEn)
                             ? orderedData : srcData;
            dstIsResult_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------------
    dma_crc_pkg::word_t readMux;
    logic               readHit;

    // Unused status bits stay zero by construction.
    always_comb
    begin
        readHit = 1'b1;
        readMux = `RST_WORD;
        unique case ({araddr[7:2], 2'b00})
            `OFS_STATUS:    readMux = {28'h0000000, lastAccessDir_q,
                                       lastActiveChannel_q};
            `OFS_LAST_ADDR: readMux = dmaLastAddress_q;
            `OFS_CONTROL:   readMux = control_q;
            `OFS_POLY:      readMux = poly_q;
            `OFS_CRC_DATA:  readMux = crcValue;
            default:        readHit = 1'b0;
        endcase
    end

    // One read at a time; arready drops while the answer waits.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rresp_q   <= `RESP_OKAY;
            rdata_q   <= `RST_WORD;
        end
        else if (rvalid_q)
        begin
            if (rready)
            begin
                rvalid_q  <= 1'b0;
                arready_q <= 1'b1;
            end
        end
        else if (arvalid && arready_q)
        begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rdata_q   <= readMux;
            rresp_q   <= readHit ? `RESP_OKAY : `RESP_SLVERR;
        end
        else
        begin
            arready_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Output drive
    // ------------------------------------------------------------------
    assign awready     = awready_q;
    assign wready      = wready_q;
    assign bvalid      = bvalid_q;
    assign bresp       = bresp_q;
    assign arready     = arready_q;
    assign rvalid      = rvalid_q;
    assign rresp       = rresp_q;
    assign rdata       = rdata_q;
    assign dstValid    = dstValid_q;
    assign dstAddr     = dstAddr_q;
    assign dstData     = dstData_q;
    assign dstIsResult = dstIsResult_q;

endmodule : dma_crc_unit

// ---- verification/dma_crc_unit_properties.sv ----
`timescale 1ns/1ns
module dma_crc_chk (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst_b,
    // Register read channel
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic [7:0]  araddr,
    input wire logic [31:0] rdata,
    input wire logic [1:0]  rresp,
    input wire logic        rvalid,
    input wire logic        rready,
    // Datapath
    input wire logic        srcValid,
    input wire logic [31:0] srcDestAddr,
    input wire logic        blockDone,
    input wire logic [31:0] chanDestStartAddr,
    input wire logic        dstValid,
    input wire logic [31:0] dstAddr,
    input wire logic        dstIsResult
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // A destination write always has a beat or a block end as its cause.
    a_dst_cause: assert property (dstValid |->
        $past(srcValid) || $past(blockDone)) else $error("stray write");
    a_pass_addr: assert property (dstValid && !dstIsResult |->
        dstAddr == $past(srcDestAddr)) else $error("bad write address");
    a_result_addr: assert property (dstIsResult |-> $past(blockDone)
        && dstAddr == $past(chanDestStartAddr)) else $error("bad result");
    // Reads answer one cycle after the address is taken, then drop.
    a_rd_answer: assert property (arvalid && arready |=> rvalid)
        else $error("late read answer");
    a_rd_once: assert property (rvalid && rready |=> !rvalid)
        else $error("read answer repeated");
    a_stat_zero: assert property (arvalid && arready && araddr == 8'h00
        |=> rdata[31:4] == 28'h0) else $error("status spare bits set");
    a_ctl_zero: assert property (arvalid && arready && araddr == 8'h08
        |=> (rdata & ~32'h39001fe7) == 32'h0) else $error("control spare set");
    a_unmapped: assert property (arvalid && arready && araddr == 8'h14
        |=> rresp == 2'h2 && rdata == 32'h0) else $error("unmapped read");
endmodule : dma_crc_chk
bind dma_crc_unit dma_crc_chk chk (.*);

// ---- verification/dma_src_model.sv ----
`timescale 1ns/1ns
module dma_src_model (
    // Clock
    input wire logic clk,
    // Channel datapath side
    output logic        busAccValid,
    output logic        busAccRead,
    output logic [2:0]  busAccChannel,
    output logic [31:0] busAccAddr,
    output logic        srcValid,
    output logic [2:0]  srcChannel,
    output logic [31:0] srcData,
    output logic [31:0] srcDestAddr,
    output logic        blockDone,
    output logic [2:0]  blockChannel,
    output logic [31:0] chanDestStartAddr
);
    // Quiet at time zero; released data lines flip so stale data never match.
    initial {busAccValid, busAccRead, busAccChannel, busAccAddr, srcValid,
        srcChannel, srcData, srcDestAddr, blockDone, blockChannel,
        chanDestStartAddr} = '0;
    task acc(input logic r, input logic [2:0] c, input logic [31:0] a);
        {busAccValid, busAccRead, busAccChannel, busAccAddr} <= {1'b1, r, c, a};
        @(posedge clk);
        {busAccValid, busAccAddr} <= {1'b0, ~a};
    endtask : acc
    // Only word-aligned addresses are ever issued.
    task beat(input logic [2:0] c, input logic [31:0] d, input logic [31:0] a);
        {srcValid, srcChannel, srcData, srcDestAddr} <= {1'b1, c, d, a};
        @(posedge clk);
        {srcValid, srcData} <= {1'b0, ~d};
    endtask : beat
    task done(input logic [2:0] c, input logic [31:0] a);
        {blockDone, blockChannel, chanDestStartAddr} <= {1'b1, c, a};
        @(posedge clk);
        {blockDone, chanDestStartAddr} <= {1'b0, ~a};
    endtask : done
endmodule : dma_src_model

// ---- verification/dma_crc_unit_tb_top.sv ----
`timescale 1ns/1ns
module dma_crc_unit_tb_top;
    logic clk, rst_b, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, busAccValid, busAccRead;
    logic srcValid, blockDone, dstValid, dstIsResult;
    logic [1:0] bresp, rresp;
    logic [2:0] busAccChannel, srcChannel, blockChannel;
    logic [3:0] wstrb;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, busAccAddr, srcData, srcDestAddr;
    logic [31:0] chanDestStartAddr, dstAddr, dstData;
    int error_cnt, num_checks;
    dma_crc_unit dut (.*);
    dma_src_model src (.*);
    task chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    // Bus master: valid held until taken; ready held until the answer.
    task wr(input logic [7:0] a, input logic [31:0] d);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
        do begin @(posedge clk); if (awready) awvalid <= 0; if (wready) wvalid <= 0; end
        while (!bvalid);
        bready <= 0;
        chk(bresp, a == 8'h14 ? 32'h2 : 32'h0);
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] e);
        {araddr, arvalid, rready} <= {a, 2'h3};
        do begin @(posedge clk); if (arready) arvalid <= 0; end while (!rvalid);
        chk(rdata, e);
    endtask : rd
    task s_regs();
        for (int i = 0; i < 5; i++) rd(8'(i * 4), 32'h0);
        wr(8'h08, 32'hffffffff);
        rd(8'h08, 32'h39001fa7);
        wr(8'h08, 32'h00000040);
        rd(8'h08, 32'h00000040);
        wr(8'h00, 32'hf);
        rd(8'h00, 32'h0);
        wr(8'h14, 32'h1);
        rd(8'h14, 32'h0);
    endtask : s_regs
    task s_status();
        src.acc(1'b1, 3'h5, 32'h10000004);
        rd(8'h00, 32'hd);
        rd(8'h04, 32'h10000004);
        src.acc(1'b0, 3'h2, 32'h20000008);
        rd(8'h00, 32'h2);
    endtask : s_status
    // Each byte order on a routed channel, then unrouted and unreordered.
    task s_reorder();
        logic [31:0] e [6];
        e = '{32'h11223344, 32'h44332211, 32'h33441122, 32'h22114433,
              32'h11223344, 32'h11223344};
        for (int i = 0; i < 6; i++)
        begin
            wr(8'h08, i < 4 ? 32'h08000081 | (i << 28) : 32'h10000081 | (5 - i) << 27);
            src.beat(i == 4 ? 3'h3 : 3'h1, 32'h11223344, 32'h100);
            #1 chk(dstData, e[i]);
            @(posedge clk);
        end
    endtask : s_reorder
    // Append checksum: beats stay in the engine, the sum lands at block end.
    task s_append();
        wr(8'h08, 32'h000000e0);
        src.beat(3'h0, 32'h45000073, 32'h300);
        #1 chk({31'h0, dstValid}, 32'h0);
        @(posedge clk);
        src.beat(3'h0, 32'hffff0001, 32'h304);
        src.done(3'h0, 32'h200);
        #1 chk(dstData, 32'h4574);
        chk(dstAddr ^ {31'h0, dstIsResult}, 32'h201);
        @(posedge clk);
        rd(8'h10, 32'h4574);
    endtask : s_append
    task s_lfsr();
        for (int i = 0; i < 3; i++)
        begin
            wr(8'h0c, i ? 32'he0 : 32'h07);
            wr(8'h08, i[1] ? 32'h010000a0 : 32'h00000780 | i << 24);
            wr(8'h10, 32'h0);
            src.beat(3'h0, i ? 32'h80000000 >> 8 * i : 32'h100, 32'h0);
            rd(8'h10, i[1] ? 1 : i ? 32'ha8 : 32'h15);
        end
    endtask : s_lfsr
    task results();
        if (error_cnt == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : results
    initial begin clk = 0; forever #5 clk = ~clk; end
    // Main sequence after ten cycles of reset.
    initial
    begin
        {rst_b, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr} = '0;
        {wdata, wstrb} = {32'h0, 4'hf};
        repeat (10) @(posedge clk);
        rst_b <= 1;
        @(posedge clk);
        s_regs();
        s_status();
        s_reorder();
        s_append();
        s_lfsr();
        results();
    end
    // Watchdog well past the roughly 130 cycles the tests need.
    initial begin #100000; error_cnt++; results(); end
endmodule : dma_crc_unit_tb_top
